/* File: common/clhp_pkg.sv */
package clhp_pkg;
    localparam int          CLK_MHZ          = 200;
    localparam int          INIT_BUSY_MS     = 40;
    localparam int          INIT_BUSY_CYC    = INIT_BUSY_MS * 1000 * CLK_MHZ;
    localparam int          IO_LOW_MS        = 40;
    localparam int          IO_LOW_CYC       = IO_LOW_MS * 1000 * CLK_MHZ;
    // Strobe timing: cycle 1200 ns, pulse 480 ns, setup 80 ns
    localparam int          EN_CYCLE_NS      = 1200;
    localparam int          EN_PULSE_NS      = 480;
    localparam int          SETUP_NS         = 80;
    localparam int          EN_PULSE_CYC     = (EN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int          SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          EN_LOW_CYC       = EN_PULSE_CYC;
    localparam int          READ_SAMPLE_CYC  = EN_PULSE_CYC - 1;
    // Function-set instruction: code bit 5, width bit 4
    localparam int          FSET_BIT         = 5;
    localparam int          WIDTH_BIT        = 4;
    localparam logic [7:0]  FSET_MASK        = 8'hE0;
    localparam logic [7:0]  FSET_CODE        = 8'h20;
    localparam logic        WIDTH_RST        = 1'b1;
    localparam logic [6:0]  ADDR_RST         = 7'h00;
    localparam logic [7:0]  DATA_RST         = 8'h00;
endpackage

/* File: common/clhp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface clhp_if;
    logic       reg_sel;
    logic       rd_wr;
    logic       enable;
    logic [7:0] bus_line_h;
    logic [7:0] bus_line_h_oe;
    logic [7:0] bus_line_d;
    logic [7:0] bus_line_d_oe;
    modport dev  (input  reg_sel, rd_wr, enable, bus_line_h, bus_line_h_oe,
                  output bus_line_d, bus_line_d_oe);
    modport host (output reg_sel, rd_wr, enable, bus_line_h, bus_line_h_oe,
                  input  bus_line_d, bus_line_d_oe);
endinterface
`default_nettype wire

/* File: verilog/clhp_device.sv */
`timescale 1ns/100ps
`default_nettype none
module clhp_device #(
    parameter int INIT_CYC = clhp_pkg::INIT_BUSY_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    clhp_if.dev              bus,
    input  wire logic        busy_in,
    input  wire logic [6:0]  address_pointer,
    input  wire logic [7:0]  rd_data,
    output logic             wr_valid,
    output logic             wr_is_data,
    output logic [7:0]       wr_byte,
    output logic             rd_done,
    output logic             rd_is_data,
    output logic             bus_width_select,
    output logic             busy_indicator
);
    import clhp_pkg::*;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [10:0] meta_r;
    logic [10:0] sync_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {bus.reg_sel, bus.rd_wr, bus.enable, bus.bus_line_h};
            sync_r <= meta_r;
        end
    end
    logic       s_rs;
    logic       s_rw;
    logic       s_en;
    logic [7:0] s_db;
    assign {s_rs, s_rw, s_en, s_db} = sync_r;

    // ************************************************
    // Transfer state
    // ************************************************
    logic        en_d_r,   en_d_nxt;
    logic        width_r,  width_nxt;
    logic        phase_r,  phase_nxt;
    logic [3:0]  hi_r,     hi_nxt;
    logic [7:0]  dout_r,   dout_nxt;
    logic [7:0]  doe_r,    doe_nxt;
    logic        wv_r,     wv_nxt;
    logic        wd_r,     wd_nxt;
    logic [7:0]  wb_r,     wb_nxt;
    logic        rdn_r,    rdn_nxt;
    logic        rdd_r,    rdd_nxt;
    logic [31:0] init_r,   init_nxt;
    logic        busy_r,   busy_nxt;
    logic [7:0]  rbyte;
    logic [7:0]  full;
    logic        fall;
    logic        rise;

    always_comb begin
        en_d_nxt  = s_en;
        width_nxt = width_r;
        phase_nxt = phase_r;
        hi_nxt    = hi_r;
        dout_nxt  = dout_r;
        doe_nxt   = doe_r;
        wv_nxt    = 1'b0;
        wd_nxt    = wd_r;
        wb_nxt    = wb_r;
        rdn_nxt   = 1'b0;
        rdd_nxt   = rdd_r;
        init_nxt  = init_r;
        busy_nxt  = busy_r;
        rise      = s_en && !en_d_r;
        fall      = !s_en && en_d_r;
        rbyte     = s_rs ? rd_data : {busy_r | busy_in, address_pointer};
        full      = {hi_r, s_db[7:4]};
        if (init_r != 32'h0000_0000) begin
            init_nxt = init_r - 32'h0000_0001;
        end else begin
            busy_nxt = 1'b0;
        end
        if (rise && s_rw) begin
            if (!width_r) begin
                // High nibble then low on upper lines
                dout_nxt = phase_r ? {rbyte[3:0], 4'h0}
                                   : {rbyte[7:4], 4'h0};
                doe_nxt  = 8'hF0;
            end else begin
                dout_nxt = rbyte;
                doe_nxt  = 8'hFF;
            end
        end
        if (fall) begin
            doe_nxt = 8'h00;
            if (!width_r) begin
                phase_nxt = !phase_r;
                if (!phase_r) begin
                    hi_nxt = s_db[7:4];
                end else if (s_rw) begin
                    rdn_nxt = 1'b1;
                    rdd_nxt = s_rs;
                end else begin
                    wv_nxt = 1'b1;
                    wd_nxt = s_rs;
                    wb_nxt = full;
                    if (!s_rs && (full & FSET_MASK) == FSET_CODE
                        && full[WIDTH_BIT] != width_r) begin
                        width_nxt = full[WIDTH_BIT];
                        phase_nxt = 1'b0;
                    end
                end
            end else if (s_rw) begin
                rdn_nxt = 1'b1;
                rdd_nxt = s_rs;
            end else begin
                wv_nxt = 1'b1;
                wd_nxt = s_rs;
                wb_nxt = s_db;
                if (!s_rs && (s_db & FSET_MASK) == FSET_CODE) begin
                    width_nxt = s_db[WIDTH_BIT];
                    phase_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_d_r  <= 1'b0;
            width_r <= WIDTH_RST;
            phase_r <= 1'b0;
            hi_r    <= 4'h0;
            dout_r  <= DATA_RST;
            doe_r   <= 8'h00;
            wv_r    <= 1'b0;
            wd_r    <= 1'b0;
            wb_r    <= DATA_RST;
            rdn_r   <= 1'b0;
            rdd_r   <= 1'b0;
            init_r  <= 32'(INIT_CYC);
            busy_r  <= 1'b1;
        end else begin
            en_d_r  <= en_d_nxt;
            width_r <= width_nxt;
            phase_r <= phase_nxt;
            hi_r    <= hi_nxt;
            dout_r  <= dout_nxt;
            doe_r   <= doe_nxt;
            wv_r    <= wv_nxt;
            wd_r    <= wd_nxt;
            wb_r    <= wb_nxt;
            rdn_r   <= rdn_nxt;
            rdd_r   <= rdd_nxt;
            init_r  <= init_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign bus.bus_line_d    = dout_r;
    assign bus.bus_line_d_oe = doe_r;
    assign wr_valid          = wv_r;
    assign wr_is_data        = wd_r;
    assign wr_byte           = wb_r;
    assign rd_done           = rdn_r;
    assign rd_is_data        = rdd_r;
    assign bus_width_select  = width_r;
    assign busy_indicator    = busy_r;
endmodule
`default_nettype wire

/* File: verilog/clhp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module clhp_host #(
    parameter int HOLD_CYC = clhp_pkg::IO_LOW_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    clhp_if.host             bus,
    input  wire logic        narrow,
    input  wire logic        req,
    input  wire logic        req_rd,
    input  wire logic        req_rs,
    input  wire logic [7:0]  req_byte,
    output logic             ready,
    output logic             done,
    output logic [7:0]       rsp_byte
);
    import clhp_pkg::*;

    typedef enum logic [2:0] {HOLD, IDLE, SETUP, HIGH, LOW} clhp_st_t;

    // ************************************************
    // Strobe sequencer
    // ************************************************
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= bus.bus_line_d;
            sync2_r <= sync1_r;
        end
    end

    clhp_st_t    st_r,   st_nxt;
    logic [31:0] cnt_r,  cnt_nxt;
    logic        nib_r,  nib_nxt;
    logic        nar_r,  nar_nxt;
    logic        rd_r,   rd_nxt;
    logic        rs_r,   rs_nxt;
    logic [7:0]  byte_r, byte_nxt;
    logic [7:0]  rsp_r,  rsp_nxt;
    logic        en_r,   en_nxt;
    logic [7:0]  db_r,   db_nxt;
    logic [7:0]  oe_r,   oe_nxt;
    logic        rdy_r,  rdy_nxt;
    logic        done_r, done_nxt;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        nib_nxt  = nib_r;
        nar_nxt  = nar_r;
        rd_nxt   = rd_r;
        rs_nxt   = rs_r;
        byte_nxt = byte_r;
        rsp_nxt  = rsp_r;
        en_nxt   = en_r;
        db_nxt   = db_r;
        oe_nxt   = oe_r;
        rdy_nxt  = 1'b0;
        done_nxt = 1'b0;
        unique case (st_r)
            HOLD: begin
                if (cnt_r == 32'h0000_0000) begin
                    st_nxt  = IDLE;
                    rdy_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            IDLE: begin
                rdy_nxt = 1'b1;
                if (req) begin
                    // Next request only accepted here, after whole byte
                    rdy_nxt  = 1'b0;
                    st_nxt   = SETUP;
                    cnt_nxt  = 32'(SETUP_CYC);
                    nib_nxt  = 1'b0;
                    nar_nxt  = narrow;
                    rd_nxt   = req_rd;
                    rs_nxt   = req_rs;
                    byte_nxt = req_byte;
                end
            end
            SETUP: begin
                if (nar_r) begin
                    db_nxt = nib_r ? {byte_r[3:0], 4'h0}
                                   : {byte_r[7:4], 4'h0};
                    oe_nxt = rd_r ? 8'h00 : 8'hF0;
                end else begin
                    db_nxt = byte_r;
                    oe_nxt = rd_r ? 8'h00 : 8'hFF;
                end
                if (cnt_r == 32'h0000_0000) begin
                    st_nxt  = HIGH;
                    en_nxt  = 1'b1;
                    cnt_nxt = 32'(EN_PULSE_CYC);
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            HIGH: begin
                if (cnt_r == 32'h0000_0000) begin
                    st_nxt  = LOW;
                    en_nxt  = 1'b0;
                    cnt_nxt = 32'(EN_LOW_CYC);
                    if (rd_r && nar_r) begin
                        if (nib_r) begin
                            rsp_nxt = {rsp_r[7:4], sync2_r[7:4]};
                        end else begin
                            rsp_nxt = {sync2_r[7:4], 4'h0};
                        end
                    end else if (rd_r) begin
                        rsp_nxt = sync2_r;
                    end
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            LOW: begin
                if (cnt_r == 32'h0000_0000) begin
                    oe_nxt = 8'h00;
                    db_nxt = 8'h00;
                    if (nar_r && !nib_r) begin
                        nib_nxt = 1'b1;
                        st_nxt  = SETUP;
                        cnt_nxt = 32'(SETUP_CYC);
                    end else begin
                        st_nxt   = IDLE;
                        done_nxt = 1'b1;
                        rdy_nxt  = 1'b1;
                    end
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= HOLD;
            cnt_r  <= 32'(HOLD_CYC);
            nib_r  <= 1'b0;
            nar_r  <= 1'b0;
            rd_r   <= 1'b0;
            rs_r   <= 1'b0;
            byte_r <= DATA_RST;
            rsp_r  <= DATA_RST;
            en_r   <= 1'b0;
            db_r   <= DATA_RST;
            oe_r   <= 8'hFF;
            rdy_r  <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            nib_r  <= nib_nxt;
            nar_r  <= nar_nxt;
            rd_r   <= rd_nxt;
            rs_r   <= rs_nxt;
            byte_r <= byte_nxt;
            rsp_r  <= rsp_nxt;
            en_r   <= en_nxt;
            db_r   <= db_nxt;
            oe_r   <= oe_nxt;
            rdy_r  <= rdy_nxt;
            done_r <= done_nxt;
        end
    end

    assign bus.reg_sel       = rs_r;
    assign bus.rd_wr         = rd_r;
    assign bus.enable        = en_r;
    assign bus.bus_line_h    = db_r;
    assign bus.bus_line_h_oe = oe_r;
    assign ready             = rdy_r;
    assign done              = done_r;
    assign rsp_byte          = rsp_r;
endmodule
`default_nettype wire

/* File: sim/clhp_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module clhp_sva #(
    parameter int HOLD_CYC = 50
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       reg_sel,
    input wire logic       rd_wr,
    input wire logic       enable,
    input wire logic [7:0] bus_line_h,
    input wire logic [7:0] bus_line_h_oe,
    input wire logic [7:0] bus_line_d_oe
);
    import clhp_pkg::*;
    // ****************************
    // Hold and strobe timing counters
    // ****************************
    logic [15:0] hold_r, hold_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
    always_comb begin
        hold_nxt = hold_r + {15'h0000, hold_r != 16'hFFFF};
        hi_nxt = enable ? hi_r + 16'h0001 : 16'h0000;
        lo_nxt = enable ? 16'h0000 : lo_r + {15'h0000, lo_r != 16'hFFFF};
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 16'h0000;
            hi_r <= 16'h0000;
            lo_r <= 16'hFFFF;
        end else begin
            hold_r <= hold_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end
    // ****************************
    // Bus checks
    // ****************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_hold_lines_low: assert property (hold_r < HOLD_CYC |->
        !enable && !reg_sel && !rd_wr && bus_line_h == 8'h00)
        else $error("lines active during hold");
    a_pulse_width: assert property (!enable && hi_r != 16'h0000 |->
        hi_r >= EN_PULSE_CYC)
        else $error("strobe too short");
    a_nibble_gap: assert property (enable && lo_r != 16'h0000 |->
        lo_r >= EN_LOW_CYC)
        else $error("strobe gap too short");
    a_ctrl_stable: assert property (enable && $past(enable) |->
        $stable(reg_sel) && $stable(rd_wr) && $stable(bus_line_h))
        else $error("lines moved during strobe");
    a_write_upper: assert property (enable && !rd_wr |->
        bus_line_h_oe[7:4] == 4'hF)
        else $error("upper lines undriven on write");
    a_read_release: assert property (enable && rd_wr |->
        bus_line_h_oe == 8'h00)
        else $error("host drives during read");
    a_dev_quiet: assert property (enable && !rd_wr |->
        bus_line_d_oe == 8'h00)
        else $error("device drives during write");
    a_dev_drive: assert property ($rose(enable) && rd_wr |->
        ##[1:8] bus_line_d_oe[7:4] == 4'hF)
        else $error("device silent on read");
    a_dev_release: assert property ($fell(enable) |->
        ##8 bus_line_d_oe == 8'h00)
        else $error("device holds bus after strobe");
endmodule
`default_nettype wire

/* File: sim/clhp_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module clhp_bench;
    import clhp_pkg::*;
    localparam int INIT = 50;
    localparam int HOLD = 50;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       busy_in = 1'b0;
    logic [6:0] ptr = 7'h00;
    logic [7:0] rd_data = 8'h00;
    logic       narrow = 1'b0;
    logic       req = 1'b0;
    logic       req_rd = 1'b0;
    logic       req_rs = 1'b0;
    logic [7:0] req_byte = 8'h00;
    logic       wr_valid, wr_is_data, rd_done, rd_is_data;
    logic       width, busy, ready, done;
    logic [7:0] wr_byte, rsp_byte;
    int         fails = 0;
    int         num_checks = 0;
    int         nwr = 0;
    int         nrd = 0;
    clhp_if bus_if ();
    clhp_device #(.INIT_CYC(INIT)) u_clhp_device (
        .mclk(mclk), .rst_n(rst_n), .bus(bus_if), .busy_in(busy_in),
        .address_pointer(ptr), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_is_data(wr_is_data), .wr_byte(wr_byte), .rd_done(rd_done),
        .rd_is_data(rd_is_data), .bus_width_select(width),
        .busy_indicator(busy));
    clhp_host #(.HOLD_CYC(HOLD)) u_clhp_host (
        .mclk(mclk), .rst_n(rst_n), .bus(bus_if), .narrow(narrow),
        .req(req), .req_rd(req_rd), .req_rs(req_rs), .req_byte(req_byte),
        .ready(ready), .done(done), .rsp_byte(rsp_byte));
    clhp_sva #(.HOLD_CYC(HOLD)) u_clhp_sva (
        .mclk(mclk), .rst_n(rst_n), .reg_sel(bus_if.reg_sel),
        .rd_wr(bus_if.rd_wr), .enable(bus_if.enable),
        .bus_line_h(bus_if.bus_line_h), .bus_line_h_oe(bus_if.bus_line_h_oe),
        .bus_line_d_oe(bus_if.bus_line_d_oe));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (wr_valid === 1'b1) begin
            nwr++;
        end
        if (rd_done === 1'b1) begin
            nrd++;
        end
    end
    // ****************************
    // Compare and transfer tasks
    // ****************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic xfer(input logic n, input logic rd, input logic rs,
                        input logic [7:0] b, input logic [7:0] st);
        int w;
        w = 0;
        @(posedge mclk);
        #1;
        while (ready !== 1'b1 && w < 2000) begin
            @(posedge mclk);
            #1;
            w++;
        end
        @(posedge mclk);
        narrow <= n;
        req_rd <= rd;
        req_rs <= rs;
        req_byte <= b;
        busy_in <= st[7];
        ptr <= st[6:0];
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
        w = 0;
        do begin
            @(posedge mclk);
            #1;
            w++;
        end while (done !== 1'b1 && w < 2000);
        chk1(done, 1'b1);
    endtask
    task automatic t_reset();
        #1;
        chk1(width, 1'b1);
        chk1(busy, 1'b1);
        chk1(ready, 1'b0);
        repeat (INIT - 10) @(posedge mclk);
        #1;
        chk1(busy, 1'b1);
        repeat (30) @(posedge mclk);
        #1;
        chk1(busy, 1'b0);
    endtask
    task automatic t_wide();
        int c;
        int r;
        c = nwr;
        r = nrd;
        @(posedge mclk);
        rd_data <= 8'h3C;
        xfer(1'b0, 1'b0, 1'b1, 8'hA5, 8'h00);
        chk8(wr_byte, 8'hA5);
        chk1(wr_is_data, 1'b1);
        chk8(8'(nwr - c), 8'h01);
        xfer(1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
        chk8(rsp_byte, 8'h3C);
        chk1(rd_is_data, 1'b1);
        xfer(1'b0, 1'b1, 1'b0, 8'h00, 8'hC7);
        chk8(rsp_byte, 8'hC7);
        chk1(rd_is_data, 1'b0);
        chk8(8'(nrd - r), 8'h02);
        xfer(1'b0, 1'b0, 1'b0, 8'h28, 8'h00);
        chk1(width, 1'b0);
        chk1(wr_is_data, 1'b0);
    endtask
    task automatic t_narrow();
        int c;
        int r;
        c = nwr;
        r = nrd;
        xfer(1'b1, 1'b0, 1'b1, 8'h5A, 8'h00);
        chk8(wr_byte, 8'h5A);
        chk8(8'(nwr - c), 8'h01);
        @(posedge mclk);
        rd_data <= 8'h11;
        xfer(1'b1, 1'b1, 1'b0, 8'h00, 8'hB5);
        chk8(rsp_byte, 8'hB5);
        chk1(rd_is_data, 1'b0);
        @(posedge mclk);
        rd_data <= 8'hC3;
        xfer(1'b1, 1'b1, 1'b1, 8'h00, 8'h00);
        chk8(rsp_byte, 8'hC3);
        chk8(8'(nrd - r), 8'h02);
    endtask
    task automatic t_restore();
        xfer(1'b1, 1'b0, 1'b0, 8'h30, 8'h00);
        chk1(width, 1'b1);
        xfer(1'b0, 1'b0, 1'b1, 8'h96, 8'h00);
        chk8(wr_byte, 8'h96);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_wide();
        t_narrow();
        t_restore();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
